// File: design/accel_event_config_regs.sv
// Register bank and shock, motion and stillness detection of the accelerometer
// Contract
// - every register eight bits, one address
// - index zero returns fixed identity code
// - shock magnitude compared to shock level
// - signed trim added to output data
// - shock must not outlast max length
// - zero max length disables all shocks
// - gap time precedes second shock span
// - zero gap or span disables double
// - second shock must begin within span
// - motion compared to motion level
// - stillness compared to still level
// - stillness needs still duration seconds
// - stillness filtered, shock and motion raw
// - stillness only fires on a sample
// - zero duration fires on low sample
// - coupling and axis bits of control
// - coupling zero direct, one relative
// - motion reference latched at detection start
// - still reference refreshed when level exceeded
// - rate and cause have nonzero reset
// - motion any axis, stillness all axes
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "accel_event_regs.svh"

module accel_event_config_regs import accel_event_pkg::*; #(
  parameter int STEP_CYC = `SHOCK_STEP_NS / `CLK_PERIOD_NS,
  parameter int STEPS_PER_SEC = `STILL_STEP_NS / `SHOCK_STEP_NS,
  parameter int TRIM_SHIFT = `TRIM_SHIFT_DEF,
  parameter int LEVEL_SHIFT = `LEVEL_SHIFT_DEF,
  parameter logic [7:0] ID_CODE = `ID_CODE_DEF // Arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire trio_t raw_sample_i,
  input wire trio_t filt_sample_i,
  input wire logic sample_strobe_i,
  input wire logic [7:0] queue_status_i,
  output ext_cfg_t ext_cfg_o,
  output logic [7:0] event_cause_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] rw_q [0:63]; // Writable bank, one byte per index
  logic [7:0] next_rw [0:63];
  logic bvalid_q, next_bvalid; // Write answer pending
  logic [1:0] bresp_q, next_bresp;
  logic rvalid_q, next_rvalid; // Read answer pending
  logic [1:0] rresp_q, next_rresp;
  logic [7:0] rdata_q, next_rdata;
  logic wr_fire, rd_fire; // Bus transfers taken this edge
  logic [5:0] wr_idx, rd_idx;
  trio_t data_q, next_data; // Trimmed output data
  logic [7:0] cause_q, next_cause;
  logic [7:0] origin_q, next_origin;
  logic [31:0] pre_q, next_pre; // Step prescaler
  logic half_q, next_half; // Odd or even step
  logic step_tick, gap_tick;
  shock_state_t sh_q, next_sh;
  logic [8:0] sh_cnt_q, next_sh_cnt; // One bit wider than the limits
  logic [2:0] sh_axes_q, next_sh_axes;
  logic single_evt, double_evt;
  logic m_armed_q, next_m_armed;
  trio_t mref_q, next_mref;
  logic motion_evt;
  logic s_armed_q, next_s_armed;
  logic s_low_q, next_s_low; // Last sample was all below
  logic s_done_q, next_s_done; // Event already given
  trio_t sref_q, next_sref;
  logic [31:0] sec_pre_q, next_sec_pre;
  logic [7:0] secs_q, next_secs;
  logic still_evt;
  logic [2:0] shock_hi, motion_hi, still_lo;
  logic [15:0] sum [0:2];
  logic [17:0] shock_thr, motion_thr, still_thr;
  logic shock_above;
  logic [2:0] m_axes, s_axes;
  logic m_ac, s_ac;

  // Unsigned size of a signed value
  function automatic logic [17:0] mag(input logic signed [17:0] v);
    mag = v[17] ? 18'(-v) : 18'(v);
  endfunction : mag

  // Indices that software may write
  function automatic logic is_rw(input logic [5:0] i);
    case (i)
      `IDX_SHOCK_LEVEL, `IDX_X_TRIM, `IDX_Y_TRIM, `IDX_Z_TRIM,
      `IDX_SHOCK_MAX_LENGTH, `IDX_SHOCK_GAP_TIME, `IDX_SECOND_SHOCK_SPAN,
      `IDX_MOTION_LEVEL, `IDX_STILL_LEVEL, `IDX_STILL_DURATION,
      `IDX_MOTION_AXIS_COUPLING, `IDX_SHOCK_AXIS_SELECT,
      `IDX_SAMPLE_RATE_POWER, `IDX_POWER_CONTROL, `IDX_IRQ_MASK,
      `IDX_IRQ_PIN_ROUTE, `IDX_OUTPUT_FORMAT, `IDX_QUEUE_CONTROL: is_rw = 1'b1;
      default: is_rw = 1'b0;
    endcase
  endfunction : is_rw

  // Indices that answer; reserved and unmapped ones get an error
  function automatic logic is_mapped(input logic [5:0] i);
    case (i)
      `IDX_IDENTITY, `IDX_EVENT_AXIS_ORIGIN, `IDX_IRQ_CAUSE,
      `IDX_X_SAMPLE_LOW, `IDX_X_SAMPLE_HIGH, `IDX_Y_SAMPLE_LOW,
      `IDX_Y_SAMPLE_HIGH, `IDX_Z_SAMPLE_LOW, `IDX_Z_SAMPLE_HIGH,
      `IDX_QUEUE_STATUS: is_mapped = 1'b1;
      default: is_mapped = is_rw(i);
    endcase
  endfunction : is_mapped

  // ----------------------------------------
  // Per-axis arithmetic
  // ----------------------------------------
  assign m_axes = rw_q[`IDX_MOTION_AXIS_COUPLING][`MOTION_AXES];
  assign s_axes = rw_q[`IDX_MOTION_AXIS_COUPLING][`STILL_AXES];
  assign m_ac = rw_q[`IDX_MOTION_AXIS_COUPLING][`MOTION_AC_BIT];
  assign s_ac = rw_q[`IDX_MOTION_AXIS_COUPLING][`STILL_AC_BIT];
  // Levels brought to sample units
  assign shock_thr = 18'(rw_q[`IDX_SHOCK_LEVEL]) << LEVEL_SHIFT;
  assign motion_thr = 18'(rw_q[`IDX_MOTION_LEVEL]) << LEVEL_SHIFT;
  assign still_thr = 18'(rw_q[`IDX_STILL_LEVEL]) << LEVEL_SHIFT;

  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic signed [17:0] raw_e, filt_e, mref_e, sref_e, trim_e;
    assign raw_e = 18'($signed(raw_sample_i.axis[i]));
    assign filt_e = 18'($signed(filt_sample_i.axis[i]));
    assign mref_e = 18'($signed(mref_q.axis[i]));
    assign sref_e = 18'($signed(sref_q.axis[i]));
    // Trim of x sits lowest, matching axis order x=2
    assign trim_e = 18'($signed(rw_q[6'(`IDX_Z_TRIM - i)])) <<< TRIM_SHIFT;
    // Wraps on overflow rather than saturating
    assign sum[i] = 16'(raw_e + trim_e);
    // Shock and motion look at raw samples, stillness at filtered
    assign shock_hi[i] = mag(raw_e) > shock_thr;
    assign motion_hi[i] = mag(m_ac ? raw_e - mref_e : raw_e) > motion_thr;
    assign still_lo[i] = mag(s_ac ? filt_e - sref_e : filt_e) < still_thr;
  end

  // ----------------------------------------
  // Bus slave and register bank
  // ----------------------------------------
  // One write and one read in flight; address and data taken together
  assign wr_fire = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
  assign rd_fire = s_axi_arvalid_i & ~rvalid_q;
  assign wr_idx = s_axi_awaddr_i[7:2];
  assign rd_idx = s_axi_araddr_i[7:2];
  assign s_axi_awready_o = wr_fire;
  assign s_axi_wready_o = wr_fire;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = {24'h000000, rdata_q};

  // Next values of the bank and both answer channels
  always_comb begin
    next_rw = rw_q;
    // Only writable indices store; others drop the data
    if (wr_fire && s_axi_wstrb_i[0] && is_rw(wr_idx)) begin
      next_rw[wr_idx] = s_axi_wdata_i[7:0];
    end
    next_bvalid = wr_fire | (bvalid_q & ~s_axi_bready_i);
    next_bresp = bresp_q;
    if (wr_fire) begin
      next_bresp = is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    next_rvalid = rd_fire | (rvalid_q & ~s_axi_rready_i);
    next_rresp = rresp_q;
    next_rdata = rdata_q;
    if (rd_fire) begin
      next_rresp = is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      case (rd_idx)
        `IDX_IDENTITY: next_rdata = ID_CODE;
        `IDX_EVENT_AXIS_ORIGIN: next_rdata = origin_q;
        `IDX_IRQ_CAUSE: next_rdata = cause_q;
        `IDX_X_SAMPLE_LOW: next_rdata = data_q.axis[2][7:0];
        `IDX_X_SAMPLE_HIGH: next_rdata = data_q.axis[2][15:8];
        `IDX_Y_SAMPLE_LOW: next_rdata = data_q.axis[1][7:0];
        `IDX_Y_SAMPLE_HIGH: next_rdata = data_q.axis[1][15:8];
        `IDX_Z_SAMPLE_LOW: next_rdata = data_q.axis[0][7:0];
        `IDX_Z_SAMPLE_HIGH: next_rdata = data_q.axis[0][15:8];
        `IDX_QUEUE_STATUS: next_rdata = queue_status_i;
        // Reserved and unmapped read as zero
        default: next_rdata = is_rw(rd_idx) ? rw_q[rd_idx] : `CFG_RESET;
      endcase
    end
  end

  // Registers of the bank and the bus answers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < 64; k++) begin
        rw_q[k] <= (k == `IDX_SAMPLE_RATE_POWER) ? `RATE_RESET : `CFG_RESET;
      end
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= `CFG_RESET;
    end else begin
      rw_q <= next_rw;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rresp_q <= next_rresp;
      rdata_q <= next_rdata;
    end
  end

  assign ext_cfg_o = '{rate: rw_q[`IDX_SAMPLE_RATE_POWER],
                       power: rw_q[`IDX_POWER_CONTROL],
                       format: rw_q[`IDX_OUTPUT_FORMAT],
                       queue: rw_q[`IDX_QUEUE_CONTROL],
                       route: rw_q[`IDX_IRQ_PIN_ROUTE]};
  assign event_cause_o = cause_q;

  // ----------------------------------------
  // Time base: shock steps and gap steps
  // ----------------------------------------
  // Free running, so the first step may come early by up to one step
  always_comb begin
    step_tick = (pre_q == 32'(STEP_CYC - 1));
    next_pre = step_tick ? 32'h00000000 : pre_q + 32'h00000001;
    // A gap step is every second shock step
    gap_tick = step_tick & half_q;
    next_half = half_q ^ step_tick;
  end

  // Prescaler registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_q <= 32'h00000000;
      half_q <= 1'b0;
    end else begin
      pre_q <= next_pre;
      half_q <= next_half;
    end
  end

  // ----------------------------------------
  // Shock sequence
  // ----------------------------------------
  assign shock_above = |(shock_hi & rw_q[`IDX_SHOCK_AXIS_SELECT][`SHOCK_AXES_EN]);

  // Single and double shock state machine
  always_comb begin
    logic [7:0] shock_max_length, gap, span;
    logic dbl_ok;
    shock_max_length = rw_q[`IDX_SHOCK_MAX_LENGTH];
    gap = rw_q[`IDX_SHOCK_GAP_TIME];
    span = rw_q[`IDX_SECOND_SHOCK_SPAN];
    dbl_ok = (gap != 8'h00) && (span != 8'h00);
    next_sh = sh_q;
    next_sh_cnt = sh_cnt_q;
    next_sh_axes = sh_axes_q;
    single_evt = 1'b0;
    double_evt = 1'b0;
    case (sh_q)
      SH_IDLE: begin
        if (shock_above) begin
          next_sh = SH_HIGH1;
          next_sh_cnt = 9'h000;
          next_sh_axes = shock_hi & rw_q[`IDX_SHOCK_AXIS_SELECT][`SHOCK_AXES_EN];
        end
      end
      SH_HIGH1: begin
        if (!shock_above) begin
          single_evt = 1'b1;
          next_sh_cnt = 9'h000;
          next_sh = dbl_ok ? SH_LATENT : SH_IDLE;
        end else if (step_tick) begin
          next_sh_cnt = sh_cnt_q + 9'h001;
          // Too long above the level: not a shock
          if (next_sh_cnt > {1'b0, shock_max_length}) next_sh = SH_OVER;
        end
      end
      SH_OVER: begin
        if (!shock_above) next_sh = SH_IDLE;
      end
      SH_LATENT: begin
        if (rw_q[`IDX_SHOCK_AXIS_SELECT][`SUPPRESS_BIT] && shock_above) begin
          next_sh = SH_IDLE;
        end else if (!dbl_ok) begin
          next_sh = SH_IDLE;
        end else if (gap_tick) begin
          next_sh_cnt = sh_cnt_q + 9'h001;
          if (next_sh_cnt >= {1'b0, gap}) begin
            next_sh = SH_SPAN;
            next_sh_cnt = 9'h000;
          end
        end
      end
      SH_SPAN: begin
        if (!dbl_ok) begin
          next_sh = SH_IDLE;
        end else if (shock_above) begin
          next_sh = SH_HIGH2;
          next_sh_cnt = 9'h000;
        end else if (gap_tick) begin
          next_sh_cnt = sh_cnt_q + 9'h001;
          if (next_sh_cnt >= {1'b0, span}) next_sh = SH_IDLE;
        end
      end
      SH_HIGH2: begin
        if (!shock_above) begin
          double_evt = 1'b1;
          next_sh = SH_IDLE;
        end else if (step_tick) begin
          next_sh_cnt = sh_cnt_q + 9'h001;
          if (next_sh_cnt > {1'b0, shock_max_length}) next_sh = SH_OVER;
        end
      end
      default: next_sh = SH_IDLE;
    endcase
    // Zero length turns the whole function off
    if (shock_max_length == 8'h00) begin
      next_sh = SH_IDLE;
      single_evt = 1'b0;
      double_evt = 1'b0;
    end
  end

  // Shock registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sh_q <= SH_IDLE;
      sh_cnt_q <= 9'h000;
      sh_axes_q <= 3'b000;
    end else begin
      sh_q <= next_sh;
      sh_cnt_q <= next_sh_cnt;
      sh_axes_q <= next_sh_axes;
    end
  end

  // ----------------------------------------
  // Motion detection, raw samples
  // ----------------------------------------
  // Reference taken on first sample after arming, re-armed after each event
  always_comb begin
    next_m_armed = m_armed_q;
    next_mref = mref_q;
    motion_evt = 1'b0;
    if (m_axes == 3'b000) begin
      next_m_armed = 1'b0;
    end else if (sample_strobe_i) begin
      if (m_ac && !m_armed_q) begin
        next_mref = raw_sample_i;
        next_m_armed = 1'b1;
      end else if (|(motion_hi & m_axes)) begin
        motion_evt = 1'b1;
        next_m_armed = 1'b0;
      end
    end
  end

  // Motion registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      m_armed_q <= 1'b0;
      mref_q <= '0;
    end else begin
      m_armed_q <= next_m_armed;
      mref_q <= next_mref;
    end
  end

  // ----------------------------------------
  // Stillness detection, filtered samples
  // ----------------------------------------
  // Seconds restart whenever a sample is not still
  always_comb begin
    logic all_lo;
    logic sec_tick;
    all_lo = &(still_lo | ~s_axes);
    sec_tick = step_tick && (sec_pre_q == 32'(STEPS_PER_SEC - 1));
    next_s_armed = s_armed_q;
    next_s_low = s_low_q;
    next_s_done = s_done_q;
    next_sref = sref_q;
    next_sec_pre = sec_pre_q;
    next_secs = secs_q;
    still_evt = 1'b0;
    if (step_tick) next_sec_pre = sec_tick ? 32'h00000000 : sec_pre_q + 32'h00000001;
    if (sec_tick && s_low_q && secs_q != 8'hff) next_secs = secs_q + 8'h01;
    if (s_axes == 3'b000) begin
      next_s_armed = 1'b0;
      next_s_low = 1'b0;
      next_s_done = 1'b0;
      next_secs = 8'h00;
    end else if (sample_strobe_i) begin
      if (s_ac && !s_armed_q) begin
        next_sref = filt_sample_i;
        next_s_armed = 1'b1;
      end else if (!all_lo) begin
        // Level exceeded: start over from this sample
        if (s_ac) next_sref = filt_sample_i;
        next_s_low = 1'b0;
        next_s_done = 1'b0;
        next_secs = 8'h00;
        next_sec_pre = 32'h00000000;
      end else begin
        next_s_low = 1'b1;
        // Judged only on a sample, so zero fires on the first low one
        if (!s_done_q && secs_q >= rw_q[`IDX_STILL_DURATION]) begin
          still_evt = 1'b1;
          next_s_done = 1'b1;
        end
      end
    end
  end

  // Stillness registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_armed_q <= 1'b0;
      s_low_q <= 1'b0;
      s_done_q <= 1'b0;
      sref_q <= '0;
      sec_pre_q <= 32'h00000000;
      secs_q <= 8'h00;
    end else begin
      s_armed_q <= next_s_armed;
      s_low_q <= next_s_low;
      s_done_q <= next_s_done;
      sref_q <= next_sref;
      sec_pre_q <= next_sec_pre;
      secs_q <= next_secs;
    end
  end

  // ----------------------------------------
  // Output data, cause and origin
  // ----------------------------------------
  // Reading the cause clears it; a new event in that cycle still sets
  always_comb begin
    logic [7:0] set;
    set = `CFG_RESET;
    next_data = data_q;
    if (sample_strobe_i) begin
      for (int k = 0; k < 3; k++) next_data.axis[k] = sum[k];
    end
    set[`CAUSE_READY_BIT] = sample_strobe_i;
    set[`CAUSE_SINGLE_BIT] = single_evt;
    set[`CAUSE_DOUBLE_BIT] = double_evt;
    set[`CAUSE_MOTION_BIT] = motion_evt;
    set[`CAUSE_STILL_BIT] = still_evt;
    next_cause = cause_q;
    if (rd_fire && rd_idx == `IDX_IRQ_CAUSE) next_cause = `CFG_RESET;
    next_cause = next_cause | set;
    // Motion or shock origin bits are overwritten by each new event of that kind; stillness leaves them
    next_origin = origin_q;
    if (motion_evt) next_origin[`ORIGIN_MOTION] = motion_hi & m_axes;
    if (single_evt || double_evt) next_origin[`ORIGIN_SHOCK] = sh_axes_q;
  end

  // Data, cause and origin registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= '0;
      cause_q <= `CAUSE_RESET;
      origin_q <= `CFG_RESET;
    end else begin
      data_q <= next_data;
      cause_q <= next_cause;
      origin_q <= next_origin;
    end
  end

endmodule : accel_event_config_regs

// File: design/accel_event_pkg.sv
// Types shared by the accelerometer event register bank
package accel_event_pkg;
  // Three axes, element 2 is x, 1 is y, 0 is z
  typedef struct packed {
    logic [2:0][15:0] axis;
  } trio_t;
  // Settings passed on to the sampling and power logic
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] power;
    logic [7:0] format;
    logic [7:0] queue;
    logic [7:0] route;
  } ext_cfg_t;
  // Shock sequence states
  typedef enum logic [2:0] {
    SH_IDLE,
    SH_HIGH1,
    SH_OVER,
    SH_LATENT,
    SH_SPAN,
    SH_HIGH2
  } shock_state_t;
endpackage : accel_event_pkg

// File: design/accel_event_regs.svh
// Register indices, field positions, reset values and timing figures
`ifndef ACCEL_EVENT_REGS_SVH
`define ACCEL_EVENT_REGS_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_IDENTITY 6'h00
`define IDX_SHOCK_LEVEL 6'h1d
`define IDX_X_TRIM 6'h1e
`define IDX_Y_TRIM 6'h1f
`define IDX_Z_TRIM 6'h20
`define IDX_SHOCK_MAX_LENGTH 6'h21
`define IDX_SHOCK_GAP_TIME 6'h22
`define IDX_SECOND_SHOCK_SPAN 6'h23
`define IDX_MOTION_LEVEL 6'h24
`define IDX_STILL_LEVEL 6'h25
`define IDX_STILL_DURATION 6'h26
`define IDX_MOTION_AXIS_COUPLING 6'h27
`define IDX_SHOCK_AXIS_SELECT 6'h2a
`define IDX_EVENT_AXIS_ORIGIN 6'h2b
`define IDX_SAMPLE_RATE_POWER 6'h2c
`define IDX_POWER_CONTROL 6'h2d
`define IDX_IRQ_MASK 6'h2e
`define IDX_IRQ_PIN_ROUTE 6'h2f
`define IDX_IRQ_CAUSE 6'h30
`define IDX_OUTPUT_FORMAT 6'h31
`define IDX_X_SAMPLE_LOW 6'h32
`define IDX_X_SAMPLE_HIGH 6'h33
`define IDX_Y_SAMPLE_LOW 6'h34
`define IDX_Y_SAMPLE_HIGH 6'h35
`define IDX_Z_SAMPLE_LOW 6'h36
`define IDX_Z_SAMPLE_HIGH 6'h37
`define IDX_QUEUE_CONTROL 6'h38
`define IDX_QUEUE_STATUS 6'h39

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define CFG_RESET 8'h00
`define RATE_RESET 8'h0a
`define CAUSE_RESET 8'h02
`define MOTION_AC_BIT 7
`define MOTION_AXES 6:4
`define STILL_AC_BIT 3
`define STILL_AXES 2:0
`define SUPPRESS_BIT 3
`define SHOCK_AXES_EN 2:0
`define CAUSE_READY_BIT 7
`define CAUSE_SINGLE_BIT 6
`define CAUSE_DOUBLE_BIT 5
`define CAUSE_MOTION_BIT 4
`define CAUSE_STILL_BIT 3
`define ORIGIN_MOTION 6:4
`define ORIGIN_SHOCK 2:0

// ----------------------------------------
// Timing and scaling
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define SHOCK_STEP_NS 625000
`define GAP_STEP_NS 1250000
`define STILL_STEP_NS 1000000000
`define TRIM_SHIFT_DEF 2
`define LEVEL_SHIFT_DEF 4
`define ID_CODE_DEF 8'h5a
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: dv/accel_event_config_regs_chk.sv
// Bus and register checks of the accelerometer register bank
`timescale 1ns/1ps
module accel_event_config_regs_chk #(
  parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary value
) (
  input logic core_clk_i,
  input logic sys_rst_i,
  input logic s_axi_awready_o,
  input logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic [1:0] s_axi_bresp_o,
  input logic s_axi_arvalid_i,
  input logic [7:0] s_axi_araddr_i,
  input logic s_axi_arready_o,
  input logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  input logic [31:0] s_axi_rdata_o,
  input logic [1:0] s_axi_rresp_o,
  input logic sample_strobe_i,
  input logic [7:0] event_cause_o
);
  // ----------------
  // Answers, holds and contents
  // ----------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  w_answer_a: assert property (s_axi_awready_o |=> s_axi_bvalid_o) else $error("no write answer");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write answer lost");
  w_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o) else $error("write overrun");
  r_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read answer");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read answer lost");
  r_width_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("read wider than a byte");
  id_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[7:2] == 6'h00 |=> s_axi_rdata_o[7:0] == ID_CODE) else $error("bad id");
  rsvd_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[7:2] inside {6'h28, 6'h29} |=> s_axi_rresp_o == 2'h2) else $error("rsvd");
  ready_flag_a: assert property (sample_strobe_i |=> event_cause_o[7])
    else $error("sample not flagged");
endmodule : accel_event_config_regs_chk

// File: dv/accel_event_config_regs_test.sv
// Self-checking bench of the accelerometer register bank
`timescale 1ns/1ps
`include "accel_event_regs.svh"
module accel_event_config_regs_test import accel_event_pkg::*;;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
  localparam logic [5:0] RW [18] = '{6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24,
    6'h25, 6'h26, 6'h27, 6'h2a, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h31, 6'h38};
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic go = 1'b0, awr, wrd, bv, arr, rv, stb;
  logic [7:0] awa = 8'h00, ara = 8'h00, qst = 8'h00, v, t;
  logic [31:0] wd = 32'h0, rdt;
  logic [1:0] br, rr;
  logic [15:0] s, e;
  trio_t raw, filt, raw_v = '0, filt_v = '0;
  ext_cfg_t cfg;
  int fails = 0, tests_run = 0, cyc = 0;
  always #12.5 clk = ~clk;
  accel_event_config_regs #(.STEP_CYC(8), .STEPS_PER_SEC(4), .ID_CODE(ID)) u_accel_event_config_regs (
    .core_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdt),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .raw_sample_i(raw),
    .filt_sample_i(filt), .sample_strobe_i(stb), .queue_status_i(qst), .ext_cfg_o(cfg),
    .event_cause_o());
  accel_sample_src u_accel_sample_src (.core_clk_i(clk), .sys_rst_i(rst), .fire_i(go),
    .raw_i(raw_v), .filt_i(filt_v), .raw_o(raw), .filt_o(filt), .strobe_o(stb));
  // Trim counts four output steps
  function automatic logic [15:0] trimmed(input logic [15:0] r, input logic [7:0] o);
    return r + {{6{o[7]}}, o, 2'h0};
  endfunction : trimmed
  task automatic chk_data(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("ERROR %0t data %h not %h", $time, g, x);
    end
  endtask : chk_data
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("ERROR %0t resp %h not %h", $time, g, x);
    end
  endtask : chk_resp
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] x = `RESP_OKAY);
    @(posedge clk);
    awa <= {i, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do @(posedge clk); while (!awr);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge clk); while (!bv);
    bry <= 1'b0;
    chk_resp(br, x);
  endtask : wr
  task automatic rd(input logic [5:0] i, input logic [7:0] d, input logic [1:0] x = `RESP_OKAY);
    @(posedge clk);
    ara <= {i, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rry <= 1'b0;
    chk_data(rdt, {24'h0, d});
    chk_resp(rr, x);
  endtask : rd
  // One sample through the front end, cause settles two cycles on
  task automatic fire(input trio_t r, input trio_t f);
    @(posedge clk);
    raw_v <= r;
    filt_v <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : fire
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    v = 8'($urandom(32'h70557619));
    qst <= 8'($urandom);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(6'h00, ID);
    rd(6'h30, `CAUSE_RESET);
    rd(6'h39, qst);
    chk_data({24'h0, cfg.rate}, {24'h0, `RATE_RESET});
    foreach (RW[k]) rd(RW[k], (RW[k] == 6'h2c) ? `RATE_RESET : `CFG_RESET);
    foreach (RW[k]) begin
      v = 8'($urandom);
      wr(RW[k], v);
      rd(RW[k], v);
      wr(RW[k], 8'h00);
    end
    wr(6'h00, 8'hff);
    rd(6'h00, ID);
    wr(6'h28, 8'h5a, `RESP_SLVERR);
    rd(6'h29, 8'h00, `RESP_SLVERR);
    $display("Register tests done");
    wr(6'h24, 8'h01);
    wr(6'h27, 8'h40);
    fire(trio_t'({16'h0010, 16'h7fff, 16'h0000}), '0);
    rd(6'h30, 8'h80);
    fire(trio_t'({16'h0011, 32'h0}), '0);
    rd(6'h30, 8'h90);
    rd(6'h2b, 8'h40);
    wr(6'h27, 8'hc0);
    fire(trio_t'({16'h1000, 32'h0}), '0);
    rd(6'h30, 8'h80);
    fire(trio_t'({16'h1011, 32'h0}), '0);
    rd(6'h30, 8'h90);
    $display("Motion tests done");
    wr(6'h25, 8'h02);
    wr(6'h27, 8'h07);
    wr(6'h1d, 8'h01);
    wr(6'h2a, 8'h07);
    fire(trio_t'({3{16'h7000}}), trio_t'({3{16'h0005}}));
    rd(6'h30, 8'h88);
    fire('0, trio_t'({16'h0040, 32'h0}));
    rd(6'h30, 8'h80);
    wr(6'h21, 8'h04);
    fire(trio_t'({3{16'h7000}}), '0);
    fire('0, '0);
    rd(6'h30, 8'hc8);
    rd(6'h2b, 8'h47);
    $display("Stillness tests done");
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 8'h80 : 8'($urandom);
      s = 16'($urandom);
      e = trimmed(s, t);
      wr(6'h1e, t);
      fire(trio_t'({s, 32'h0}), '0);
      rd(6'h32, e[7:0]);
      rd(6'h33, e[15:8]);
    end
    $display("Trim tests done");
    final_report();
  end
endmodule : accel_event_config_regs_test
bind accel_event_config_regs accel_event_config_regs_chk #(.ID_CODE(ID_CODE)) u_chk (.*);

// File: dv/accel_sample_src.sv
// Sampling front end model feeding the register bank
`timescale 1ns/1ps
module accel_sample_src import accel_event_pkg::*; (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic fire_i,
  input wire trio_t raw_i,
  input wire trio_t filt_i,
  output trio_t raw_o,
  output trio_t filt_o,
  output logic strobe_o
);
  trio_t filt_q; // Last filtered sample
  // Raw data held between samples, strobe lasts one cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      raw_o <= '0;
      filt_q <= '0;
      strobe_o <= 1'b0;
    end else begin
      strobe_o <= fire_i;
      if (fire_i) begin
        raw_o <= raw_i;
        filt_q <= filt_i;
      end
    end
  end
  // Filtered bus only valid with the strobe, garbage otherwise
  assign filt_o = strobe_o ? filt_q : ~filt_q;
endmodule : accel_sample_src
